/* File: hdl/evt_timer_pkg.sv */
// shared constants for the event counter timer unit
`default_nettype none
package evt_timer_pkg;
  // ==========================================
  // register byte offsets
  localparam logic [7:0] CTRL_OFFSET   = 8'h00;
  localparam logic [7:0] MODE_OFFSET   = 8'h04;
  localparam logic [7:0] DATA_OFFSET   = 8'h08;
  localparam logic [7:0] STATUS_OFFSET = 8'h0C;
  localparam int         ADDR_BITS     = 8;
  // ==========================================
  // control register fields
  localparam int CTRL_START_BIT = 0;
  // ==========================================
  // mode register fields
  localparam int MODE_SEL_LSB    = 0;
  localparam int PULSE_OUT_BIT   = 2;
  localparam int DIR_PIN_BIT     = 3;
  localparam int SRC_TIMER_BIT   = 4;
  localparam int EDGE_LSB        = 5;
  localparam int FREE_RUN_BIT    = 7;
  localparam int TWO_PHASE_BIT   = 8;
  localparam int MULT4_BIT       = 9;
  localparam int SW_UP_BIT       = 10;
  localparam int SRC_NEIGHBOR_BIT = 11;
  localparam int MODE_BITS       = 12;
  localparam logic [1:0] MODE_EVENT  = 2'h1;
  localparam logic [1:0] EDGE_FALL   = 2'h0;
  localparam logic [1:0] EDGE_RISE   = 2'h1;
  // ==========================================
  // status register fields
  localparam int STAT_EVENT_BIT = 0;
  localparam int STAT_AUX_BIT   = 1;
  localparam int STAT_RUN_BIT   = 2;
  // ==========================================
  // reset values and counter limits
  localparam logic [MODE_BITS-1:0] MODE_RESET = 12'h000;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [15:0] COUNT_MAX   = 16'hFFFF;
  localparam logic [15:0] COUNT_MIN   = 16'h0000;
endpackage
`default_nettype wire

/* File: hdl/pin_edge_sync.sv */
// two-flop synchroniser with edge detection for one pin
`default_nettype none
module pin_edge_sync (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic pin_in,
  output logic      level,
  output logic      rise,
  output logic      fall
);
  logic meta_reg, meta_next;
  logic sync_reg, sync_next;
  logic last_reg, last_next;

  // ==========================================
  // synchroniser and history
  always_comb begin
    meta_next = pin_in;
    sync_next = meta_reg;
    last_next = sync_reg;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      last_reg <= 1'b0;
    end else begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
      last_reg <= last_next;
    end
  end

  // edges are seen only from the second stage on
  assign level = sync_reg;
  assign rise  = sync_reg & ~last_reg;
  assign fall  = ~sync_reg & last_reg;
endmodule
`default_nettype wire

/* File: hdl/event_counter_quadrature_timer.sv */
// event counter timer unit with two-phase decoding and apb registers
// ==========================================
// What this block does
// - units 0-1 single-phase; 2-4 also two-phase
// - count pin edges or companion timer overflow
// - direction from software or select pin
// - overflow/underflow reloads unless free-run
// - ratio FFFF-n+1 up, n+1 down
// - counts only while start flag is 1
// - interrupt request on overflow or underflow
// - aux pin: port, toggle output, direction input
// - data read returns current count
// - write when stopped sets reload and counter
// - write when running sets reload only
// - free-run wraps without reloading
// - pulse output toggles on each wrap
// - two-phase uses both pins as inputs
// - two-phase direction from phase relation
// - normal: aux high, rise up, fall down
// - times four counts all edges of both except simultaneous ones
// - two low mode bits choose the mode
// - counter and reload are 16 bits
`default_nettype none
module event_counter_quadrature_timer
  import evt_timer_pkg::*;
#(
  parameter int UNIT = 2
) (
  input  wire logic                                pclk,
  input  wire logic                                presetn,
  input  wire logic                                psel,
  input  wire logic                                penable,
  input  wire logic                                pwrite,
  input  wire logic [evt_timer_pkg::ADDR_BITS-1:0] paddr,
  input  wire logic [31:0]                         pwdata,
  output logic      [31:0]                         prdata,
  output logic                                     pready,
  output logic                                     pslverr,
  input  wire logic                                count_input_pin,
  input  wire logic                                auxiliary_io_pin_in,
  output logic                                     auxiliary_io_pin_out,
  output logic                                     auxiliary_io_pin_oe,
  input  wire logic                                companion_b_unit_ovf,
  input  wire logic                                neighbor_a_unit_ovf,
  output logic                                     intr_req,
  output logic                                     overflow_out
);
  import evt_timer_pkg::*;

  // only the higher units carry the two-phase decoder
  localparam bit TWO_PHASE_OK = (UNIT >= 2);

  // refuse unit numbers that have no timer behind them
  if (UNIT < 0 || UNIT > 4) begin : g_unit_check
    $error("UNIT must be 0 to 4");
  end

  // ==========================================
  // pin synchronisers
  // both pins pass the same two stages, so their phase relation survives
  logic in_lvl, in_rise, in_fall;
  logic aux_lvl, aux_rise, aux_fall;

  pin_edge_sync in_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .pin_in  (count_input_pin),
    .level   (in_lvl),
    .rise    (in_rise),
    .fall    (in_fall)
  );

  pin_edge_sync aux_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .pin_in  (auxiliary_io_pin_in),
    .level   (aux_lvl),
    .rise    (aux_rise),
    .fall    (aux_fall)
  );

  // ==========================================
  // state
  logic                 start_reg, start_next;
  logic [MODE_BITS-1:0] mode_reg, mode_next;
  logic [15:0]          count_reg, count_next;
  logic [15:0]          reload_reg, reload_next;
  logic                 event_reg, event_next;
  logic                 aux_out_reg, aux_out_next;
  logic                 aux_oe_reg, aux_oe_next;
  logic                 intr_reg, intr_next;
  logic                 ovf_reg, ovf_next;
  logic [31:0]          prdata_reg, prdata_next;
  logic                 pready_reg, pready_next;
  logic                 pslverr_reg, pslverr_next;

  // ==========================================
  // decoded mode fields
  logic       event_mode, two_phase, mult4, free_run, pulse_out;
  logic       dir_from_pin, src_timer, sw_up;
  logic [1:0] edge_sel;

  always_comb begin
    event_mode   = (mode_reg[MODE_SEL_LSB +: 2] == MODE_EVENT);
    two_phase    = TWO_PHASE_OK & mode_reg[TWO_PHASE_BIT];
    mult4        = mode_reg[MULT4_BIT];
    free_run     = mode_reg[FREE_RUN_BIT];
    pulse_out    = mode_reg[PULSE_OUT_BIT];
    dir_from_pin = mode_reg[DIR_PIN_BIT];
    src_timer    = mode_reg[SRC_TIMER_BIT];
    sw_up        = mode_reg[SW_UP_BIT];
    edge_sel     = mode_reg[EDGE_LSB +: 2];
  end

  // ==========================================
  // count step decode
  logic step, up;

  always_comb begin
    step = 1'b0;
    up   = 1'b1;
    if (two_phase) begin
      // the phase relation decides; software direction is ignored
      if (mult4) begin
        // simultaneous edges on both pins carry no direction and are dropped
        if ((in_rise | in_fall) ^ (aux_rise | aux_fall)) begin
          step = 1'b1;
          up   = (in_rise & aux_lvl) | (in_fall & ~aux_lvl) |
                 (aux_rise & ~in_lvl) | (aux_fall & in_lvl);
        end
      end else begin
        if (aux_lvl && (in_rise || in_fall)) begin
          step = 1'b1;
          up   = in_rise;
        end
      end
    end else begin
      if (src_timer) begin
        step = mode_reg[SRC_NEIGHBOR_BIT] ? neighbor_a_unit_ovf : companion_b_unit_ovf;
      end else begin
        case (edge_sel)
          EDGE_FALL: step = in_fall;
          EDGE_RISE: step = in_rise;
          default:   step = in_rise | in_fall;
        endcase
      end
      up = dir_from_pin ? aux_lvl : sw_up;
    end
  end

  // ==========================================
  // apb decode
  // a write lands on the ready edge; unmapped writes are dropped
  logic        access, wr_en, rd_en, addr_ok;
  logic        data_wr, wrap;
  logic [31:0] rd_value;

  always_comb begin
    access  = psel & penable & ~pready_reg;
    wr_en   = psel & penable & pready_reg & pwrite & ~pslverr_reg;
    rd_en   = psel & penable & pready_reg & ~pwrite;
    addr_ok = (paddr == CTRL_OFFSET) || (paddr == MODE_OFFSET) ||
              (paddr == DATA_OFFSET) || (paddr == STATUS_OFFSET);
    data_wr = wr_en & (paddr == DATA_OFFSET);
    rd_value = 32'h0000_0000;
    case (paddr)
      CTRL_OFFSET:   rd_value[CTRL_START_BIT] = start_reg;
      MODE_OFFSET: begin
        rd_value[MODE_BITS-1:0] = mode_reg;
        if (!TWO_PHASE_OK) begin
          rd_value[TWO_PHASE_BIT] = 1'b0;
          rd_value[MULT4_BIT]     = 1'b0;
        end
      end
      DATA_OFFSET:   rd_value[15:0] = count_reg;
      STATUS_OFFSET: begin
        rd_value[STAT_EVENT_BIT] = event_reg;
        rd_value[STAT_AUX_BIT]   = aux_out_reg;
        rd_value[STAT_RUN_BIT]   = start_reg;
      end
      default:       rd_value = 32'h0000_0000;
    endcase
  end

  // ==========================================
  // bus answer
  // read data stands only in the ready cycle and reads zero otherwise
  always_comb begin
    pready_next  = access;
    pslverr_next = access & ~addr_ok;
    prdata_next  = prdata_reg;
    if (access) begin
      prdata_next = pwrite ? 32'h0000_0000 : rd_value;
    end else if (rd_en) begin
      prdata_next = 32'h0000_0000;
    end
  end

  // ==========================================
  // configuration registers
  // upper write data bits are ignored
  always_comb begin
    start_next = start_reg;
    mode_next  = mode_reg;
    if (wr_en && paddr == CTRL_OFFSET) begin
      start_next = pwdata[CTRL_START_BIT];
    end
    if (wr_en && paddr == MODE_OFFSET) begin
      mode_next = pwdata[MODE_BITS-1:0];
    end
  end

  // ==========================================
  // counter, reload and events
  // a running write leaves the count alone until the next wrap
  always_comb begin
    count_next   = count_reg;
    reload_next  = reload_reg;
    wrap         = 1'b0;
    if (event_mode && start_reg && step) begin
      if (up) begin
        wrap = (count_reg == COUNT_MAX);
        count_next = count_reg + 16'h0001;
      end else begin
        wrap = (count_reg == COUNT_MIN);
        count_next = count_reg - 16'h0001;
      end
      if (wrap && !free_run) begin
        count_next = reload_reg;
      end
      // free-run leaves the wrapped value in place
    end
    if (data_wr) begin
      reload_next = pwdata[15:0];
      if (!start_reg) begin
        count_next = pwdata[15:0];
      end
    end
  end

  always_comb begin
    intr_next = wrap;
    ovf_next  = wrap;
    // a new event wins over a software clear in the same cycle
    event_next = event_reg;
    if (wr_en && paddr == STATUS_OFFSET && pwdata[STAT_EVENT_BIT]) begin
      event_next = 1'b0;
    end
    if (wrap) begin
      event_next = 1'b1;
    end
    aux_out_next = aux_out_reg;
    if (wrap && pulse_out) begin
      aux_out_next = ~aux_out_reg;
    end
    // aux pin drives only as pulse output; otherwise it is an input or port
    aux_oe_next = event_mode & pulse_out & ~two_phase & ~dir_from_pin;
  end

  // ==========================================
  // registers
  // every output is taken from here, so no combinational path leaves the block
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      start_reg   <= 1'b0;
      mode_reg    <= MODE_RESET;
      count_reg   <= COUNT_RESET;
      reload_reg  <= COUNT_RESET;
      event_reg   <= 1'b0;
      aux_out_reg <= 1'b0;
      aux_oe_reg  <= 1'b0;
      intr_reg    <= 1'b0;
      ovf_reg     <= 1'b0;
      prdata_reg  <= 32'h0000_0000;
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      start_reg   <= start_next;
      mode_reg    <= mode_next;
      count_reg   <= count_next;
      reload_reg  <= reload_next;
      event_reg   <= event_next;
      aux_out_reg <= aux_out_next;
      aux_oe_reg  <= aux_oe_next;
      intr_reg    <= intr_next;
      ovf_reg     <= ovf_next;
      prdata_reg  <= prdata_next;
      pready_reg  <= pready_next;
      pslverr_reg <= pslverr_next;
    end
  end

  assign prdata               = prdata_reg;
  assign pready               = pready_reg;
  assign pslverr              = pslverr_reg;
  assign auxiliary_io_pin_out = aux_out_reg;
  assign auxiliary_io_pin_oe  = aux_oe_reg;
  assign intr_req             = intr_reg;
  assign overflow_out         = ovf_reg;
endmodule
`default_nettype wire

/* File: verification/evt_timer_properties.sv */
// port checker for the event counter timer
`default_nettype none
module evt_timer_properties (
  input wire logic                                pclk,
  input wire logic                                presetn,
  input wire logic                                psel,
  input wire logic                                penable,
  input wire logic                                pwrite,
  input wire logic [evt_timer_pkg::ADDR_BITS-1:0] paddr,
  input wire logic [31:0]                         prdata,
  input wire logic                                pready,
  input wire logic                                pslverr,
  input wire logic                                auxiliary_io_pin_out,
  input wire logic                                intr_req,
  input wire logic                                overflow_out
);
  timeunit 1ns;
  timeprecision 1ps;
  import evt_timer_pkg::*;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // ==========
  // register bus
  logic mapped;
  assign mapped = paddr inside {CTRL_OFFSET, MODE_OFFSET, DATA_OFFSET, STATUS_OFFSET};
  sequence access_first;
    psel && penable && !$past(penable);
  endsequence
  sequence late_ready;
    !pready ##1 pready;
  endsequence
  chk_ready_late: assert property (access_first |-> late_ready)
    else $error("ready not in second access cycle");
  chk_ready_single: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  chk_ready_access: assert property (pready |-> psel && penable)
    else $error("ready outside access");
  chk_err_unmapped: assert property (pready |-> pslverr == !mapped)
    else $error("error flag wrong for address");
  chk_err_alone: assert property (pslverr |-> pready)
    else $error("error flag without ready");
  chk_rdata_quiet: assert property (!(pready && !pwrite) |-> prdata == 32'h0)
    else $error("read data outside read answer");
  // ==========
  // wrap events
  chk_intr_mirror: assert property (intr_req == overflow_out)
    else $error("overflow pulse differs from request");
  chk_aux_cause: assert property ($changed(auxiliary_io_pin_out) |-> intr_req)
    else $error("aux output moved without a wrap");
endmodule
bind event_counter_quadrature_timer evt_timer_properties chk (.pclk, .presetn, .psel,
  .penable, .pwrite, .paddr, .prdata, .pready, .pslverr, .auxiliary_io_pin_out,
  .intr_req, .overflow_out);
`default_nettype wire

/* File: verification/pulse_source.sv */
// behavioural pulse source and two-phase encoder
`default_nettype none
module pulse_source (
  input  wire logic pclk,
  output logic      a,
  output logic      b
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    a = 1'b0;
    b = 1'b0;
  end
  // four clocks per level so the pin synchroniser never misses one
  task automatic hold(input logic na, nb);
    a <= na;
    b <= nb;
    repeat (4) @(posedge pclk);
  endtask
  task automatic pulse(input int k);
    repeat (k) begin
      hold(1'b1, b);
      hold(1'b0, b);
    end
  endtask
  // one pin moves per step; both cycles end at a low, b high
  task automatic quad(input bit up, input int k);
    repeat (k) begin
      hold(up, up);
      hold(1'b1, 1'b0);
      hold(!up, !up);
      hold(1'b0, 1'b1);
    end
  endtask
endmodule
`default_nettype wire

/* File: verification/testbench.sv */
// self-checking bench for the event counter timer
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import evt_timer_pkg::*;
  localparam logic [31:0] EV = 32'(MODE_EVENT);
  localparam logic [31:0] RISE = 32'(EDGE_RISE) << EDGE_LSB;
  localparam logic [31:0] UP = 32'h1 << SW_UP_BIT;
  localparam logic [31:0] TWO = 32'h1 << TWO_PHASE_BIT;
  localparam logic [31:0] TMR = 32'h1 << SRC_TIMER_BIT;
  logic        pclk, presetn, psel, penable, pwrite, comp, neigh, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, rd;
  wire logic   src_a, src_b, aux_out, aux_oe, aux_line, intr_req, pready, pslverr;
  wire logic [31:0] prdata;
  int          n_fail, total_checks, n_intr, seed, n;
  event_counter_quadrature_timer DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .count_input_pin(src_a),
    .auxiliary_io_pin_in(aux_line), .auxiliary_io_pin_out(aux_out),
    .auxiliary_io_pin_oe(aux_oe), .companion_b_unit_ovf(comp),
    .neighbor_a_unit_ovf(neigh), .intr_req, .overflow_out());
  pulse_source src (.pclk, .a(src_a), .b(src_b));
  assign aux_line = aux_oe ? aux_out : src_b;
  always #4 pclk = ~pclk;
  always @(posedge pclk) if (intr_req === 1'b1) n_intr <= n_intr + 1;
  task automatic give_verdict;
    if (n_fail == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, e);
    total_checks++;
    if (g !== e) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int t;
    t = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      t++;
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
    chk(32'(t), 32'h2);
  endtask
  function automatic logic [15:0] expect_cnt(input logic [15:0] c, r, input int k,
                                             input bit up, fr, output int w);
    w = 0;
    for (int i = 0; i < k; i++) begin
      if (up ? c == COUNT_MAX : c == COUNT_MIN) begin
        w++;
        c = fr ? ~c : r;
      end else c = up ? c + 16'h1 : c - 16'h1;
    end
    return c;
  endfunction
  task automatic ovf(input bit nb, input int k);
    repeat (k) begin
      comp <= !nb;
      neigh <= nb;
      @(posedge pclk);
      comp <= 1'b0;
      neigh <= 1'b0;
      repeat (1 + ($random(seed) & 3)) @(posedge pclk);
    end
    repeat (4) @(posedge pclk);
  endtask
  // ==========
  // one counting pass: s picks pin, companion, neighbour or encoder
  task automatic run(input logic [31:0] m, input logic [15:0] v, input int k,
                     input bit up, fr, input int s, mul);
    int b, w;
    logic [15:0] e;
    apb(1'b1, CTRL_OFFSET, 32'h0);
    src.hold(1'b0, s == 3 ? 1'b1 : up);
    apb(1'b1, MODE_OFFSET, m);
    apb(1'b1, DATA_OFFSET, {16'h0, v});
    apb(1'b1, CTRL_OFFSET, 32'h1);
    b = n_intr;
    if (s == 0) src.pulse(k);
    else if (s == 3) src.quad(up, k);
    else ovf(s == 2, k);
    e = expect_cnt(v, v, k * mul, up, fr, w);
    apb(1'b0, DATA_OFFSET, 32'h0);
    chk(rd, {16'h0, e});
    chk(n_intr - b, w);
  endtask
  initial begin
    repeat (30000) @(posedge pclk);
    n_fail++;
    give_verdict();
  end
  initial begin
    {pclk, presetn, psel, penable, pwrite, comp, neigh} = 7'h0;
    paddr = 8'h0;
    pwdata = 32'h0;
    n_intr = 0;
    seed = 32'h488C;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i < 4; i++) begin
      apb(1'b0, 8'(4 * i), 32'h0);
      chk(rd, 32'h0);
    end
    apb(1'b0, 8'h10, 32'h0);
    chk(32'(err), 32'h1);
    run(EV | RISE | UP | (32'h1 << PULSE_OUT_BIT), 16'hFFFD, 3, 1, 0, 0, 1);
    apb(1'b0, STATUS_OFFSET, 32'h0);
    chk(rd, 32'h7);
    chk(32'(aux_out), 32'h1);
    chk(32'(aux_oe), 32'h1);
    apb(1'b1, STATUS_OFFSET, 32'h1);
    apb(1'b0, STATUS_OFFSET, 32'h0);
    chk(rd, 32'h6);
    apb(1'b1, DATA_OFFSET, 32'hFFFE);
    apb(1'b0, DATA_OFFSET, 32'h0);
    chk(rd, 32'hFFFD);
    src.pulse(3);
    apb(1'b1, CTRL_OFFSET, 32'h0);
    src.pulse(2);
    apb(1'b0, DATA_OFFSET, 32'h0);
    chk(rd, 32'hFFFE);
    n = 3 + ($random(seed) & 7);
    run(EV | RISE, 16'(n), n + 1, 0, 0, 0, 1);
    run(EV | (32'h2 << EDGE_LSB), 16'h4, 3, 0, 0, 0, 2);
    run(EV | UP, 16'hFFFE, 2, 1, 0, 0, 1);
    run(EV | RISE | (32'h1 << FREE_RUN_BIT), 16'h1, 2, 0, 1, 0, 1);
    run(EV | RISE | (32'h1 << DIR_PIN_BIT), 16'hA, 4, 0, 0, 0, 1);
    run(EV | RISE | (32'h1 << DIR_PIN_BIT), 16'hFFFE, 2, 1, 0, 0, 1);
    chk(32'(aux_oe), 32'h0);
    n = 1 + ($random(seed) & 7);
    run(EV | UP | (32'h1 << SRC_TIMER_BIT), 16'hFFFA, n, 1, 0, 1, 1);
    run(EV | TMR | (32'h1 << SRC_NEIGHBOR_BIT), 16'h3, n, 0, 0, 2, 1);
    run(EV | TWO, 16'hFFFE, 3, 1, 0, 3, 1);
    run(EV | TWO | UP, 16'h1, 2, 0, 0, 3, 1);
    run(EV | TWO | (32'h1 << MULT4_BIT), 16'h5, 2, 0, 0, 3, 4);
    run(EV | TWO | (32'h1 << MULT4_BIT), 16'hFFFC, 1, 1, 0, 3, 4);
    run(RISE | UP, 16'h7, 3, 1, 0, 0, 0);
    give_verdict();
  end
endmodule
`default_nettype wire
